// File: hw/ehl_pkg.sv
// Purpose: Shared constants and types of the error history log.
// Assumes: One 20 MHz clock, asynchronous active-low reset.
// Notes: Parameter addresses are the documented fieldbus parameter offsets.
package ehl_pkg;
	localparam int DEPTH = 10;
	localparam int PTR_W = 4;
	localparam logic [15:0] ADDR_ERASE = 16'h3B08;
	localparam logic [15:0] ADDR_PTR_RESET = 16'h3B0A;
	localparam logic [15:0] ADDR_ERR_NUM = 16'h3C02;
	localparam logic [15:0] ADDR_CLASS = 16'h3C04;
	localparam logic [15:0] ADDR_TIME = 16'h3C06;
	localparam logic [15:0] ADDR_EXTRA = 16'h3C08;
	localparam logic [15:0] CMD_ONE = 16'h0001;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam int STATUS_ERR_BIT = 13;
	localparam logic [3:0] STATUS_OPER_FAULT = 4'h8;
	localparam logic [31:0] TIME_MAX = 32'h1FFFFFFF;
	localparam logic [2:0] CLASS_WARN = 3'h0;
	localparam logic [2:0] CLASS_QSTOP7 = 3'h1;
	localparam logic [2:0] CLASS_QSTOP89 = 3'h2;
	localparam logic [2:0] CLASS_FATAL = 3'h3;
	localparam logic [2:0] CLASS_FATAL_LOCK = 3'h4;
	localparam int ENTRY_W = 16 + 3 + 32 + 16;
	typedef struct packed {
		logic [15:0] num;
		logic [2:0] cls;
		logic [31:0] tim;
		logic [15:0] info;
	} ehl_entry_type;
	typedef enum logic [1:0] {ST_IDLE, ST_ERASE} ehl_state_type;
endpackage

// File: hw/ehl_mem_if.sv
`timescale 1ns/1ps
// Purpose: Carrier between the history controller and its entry store.
// Assumes: Same clock on both sides.
// Notes: Read data come one cycle after the read address.
interface ehl_mem_if;
	logic we;
	logic [ehl_pkg::PTR_W-1:0] waddr;
	ehl_pkg::ehl_entry_type wdata;
	logic [ehl_pkg::PTR_W-1:0] raddr;
	ehl_pkg::ehl_entry_type rdata;
	modport ctrl(output we, output waddr, output wdata, output raddr, input rdata);
	modport mem(input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// File: hw/ehl_entry_mem.sv
`timescale 1ns/1ps
// Purpose: Ten-slot entry store with registered read data.
// Assumes: Stands in for a non-volatile array; it has no reset so contents survive a logic reset.
// Notes: One write port, one read port.
module ehl_entry_mem (
	// Clock
	input wire logic clk,
	// Store port
	ehl_mem_if.mem m
);
	ehl_pkg::ehl_entry_type store [ehl_pkg::DEPTH];

	always_ff @(posedge clk) begin
		if (m.we) begin
			store[m.waddr] <= m.wdata;
		end
		m.rdata <= store[m.raddr];
	end
endmodule

// File: hw/ehl_top.sv
`timescale 1ns/1ps
// Purpose: Error reporting and ten-entry error history reached through drive parameters.
// Assumes: Parameter access is a one-cycle read or write strobe with a 16-bit address.
// Notes: The entry store and its count stand in for non-volatile memory and ignore the logic reset.
// Summary of operation
// R1 - On error, change operating status and set status word bit 13.
// R2 - Last interruption cause reads zero without error, else the cause's number.
// R3 - Each new error writes number with status information into the history; the code logs none that arrive during an erase or a shift walk.
// R4 - Consequential errors are not logged; only the triggering cause.
// R5 - History keeps the ten most recent errors.
// R6 - History contents survive power-off.
// R7 - Writing one to erase command clears all entries.
// R8 - Erase command reads nonzero while erasing, zero when done; master polls.
// R9 - Writing one to pointer reset sets read pointer to oldest entry.
// R10 - Master reads entries sequentially after resetting the pointer.
// R11 - Each error number read advances the read pointer by one; the code stops advancing once the pointer reaches 10.
// R12 - Pointer past stored entries reads error number zero.
// R13 - Position one is oldest; position ten holds the newest of ten.
// R14 - Master reads error number before other components of an entry.
// R15 - Reading error number latches the whole entry for component reads.
// R16 - Class codes 0 to 4 as warning, quick stops and fatal kinds.
// R17 - Time is 32-bit seconds from hours counter, up to 536870911.
// R18 - Additional information is a 16-bit error-dependent value.
// R19 - Class 4 errors survive a fault reset; only power cycling clears.
// R20 - With ten stored, a new error drops the oldest and shifts down.
module ehl_top (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Error source
	input wire logic err_evt,
	input wire logic [15:0] err_num,
	input wire logic [2:0] err_class,
	input wire logic [15:0] err_info,
	input wire logic [31:0] op_seconds,
	input wire logic fault_reset,
	input wire logic [3:0] oper_state,
	// Parameter access
	input wire logic par_rd,
	input wire logic par_wr,
	input wire logic [15:0] par_addr,
	input wire logic [31:0] par_wdata,
	output logic [31:0] par_rdata,
	output logic par_ack,
	// Status
	output logic [15:0] drive_status_word,
	output logic [15:0] last_interrupt_cause
);
	// ----------------------------------------------------------------
	// Entry store
	// ----------------------------------------------------------------
	ehl_mem_if mif();

	ehl_entry_mem u_mem (
		.clk(clk),
		.m(mif)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [ehl_pkg::PTR_W-1:0] count_r;
	logic [ehl_pkg::PTR_W-1:0] rd_ptr_r;
	logic [ehl_pkg::PTR_W-1:0] walk_r;
	logic fault_r;
	logic [15:0] cause_r;
	logic [2:0] cause_class_r;
	ehl_pkg::ehl_state_type state_r;
	logic shift_busy_r;
	logic [ehl_pkg::PTR_W-1:0] shift_idx_r;
	ehl_pkg::ehl_entry_type pending_r;
	ehl_pkg::ehl_entry_type hold_r;
	logic latch_pend_r;
	logic latch_empty_r;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [ehl_pkg::PTR_W-1:0] inc_ptr(input logic [ehl_pkg::PTR_W-1:0] p);
		inc_ptr = p + 4'h1;
	endfunction

	function automatic logic [31:0] clamp_time(input logic [31:0] t);
		clamp_time = (t > ehl_pkg::TIME_MAX) ? ehl_pkg::TIME_MAX : t;
	endfunction

	function automatic logic is_last(input logic [ehl_pkg::PTR_W-1:0] p);
		is_last = p == 4'(ehl_pkg::DEPTH - 1);
	endfunction

	logic wr_erase;
	logic wr_ptr_reset;
	logic rd_num;
	logic new_err;
	logic full;
	logic log_start;
	logic erase_done;
	assign wr_erase = par_wr && par_addr == ehl_pkg::ADDR_ERASE && par_wdata[15:0] == ehl_pkg::CMD_ONE;
	assign wr_ptr_reset = par_wr && par_addr == ehl_pkg::ADDR_PTR_RESET && par_wdata[15:0] == ehl_pkg::CMD_ONE;
	assign rd_num = par_rd && par_addr == ehl_pkg::ADDR_ERR_NUM;
	// Only the first error of a fault episode is logged.
	assign new_err = err_evt && !fault_r; // R4
	assign full = count_r == 4'(ehl_pkg::DEPTH);
	// A log starts only when the store is free: erase and shift walks own its port.
	assign log_start = state_r == ehl_pkg::ST_IDLE && !wr_erase && !shift_busy_r && new_err;
	assign erase_done = state_r == ehl_pkg::ST_ERASE && is_last(walk_r);

	// ----------------------------------------------------------------
	// Fault state and last cause
	// ----------------------------------------------------------------
	// A new error outranks a fault reset, but an error that meets a fault reset while the flag is set is dropped.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fault_r <= 1'b0;
			cause_r <= ehl_pkg::ZERO16;
			cause_class_r <= ehl_pkg::CLASS_WARN;
		end else if (new_err) begin
			fault_r <= 1'b1;
			cause_r <= err_num; // R2
			cause_class_r <= err_class;
		end else if (fault_reset && fault_r && cause_class_r != ehl_pkg::CLASS_FATAL_LOCK) begin // R19
			fault_r <= 1'b0;
			cause_r <= ehl_pkg::ZERO16; // R2
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			drive_status_word <= ehl_pkg::ZERO16;
			last_interrupt_cause <= ehl_pkg::ZERO16;
		end else begin
			// Fields other than the state code and the error bit read as zero.
			drive_status_word <= ehl_pkg::ZERO16;
			drive_status_word[3:0] <= fault_r ? ehl_pkg::STATUS_OPER_FAULT : oper_state; // R1
			drive_status_word[ehl_pkg::STATUS_ERR_BIT] <= fault_r; // R1
			last_interrupt_cause <= cause_r;
		end
	end

	// ----------------------------------------------------------------
	// Logging, shifting and erasing
	// ----------------------------------------------------------------
	// A log while full runs a shift walk first: slot i+1 is read, then written
	// into slot i, one slot per two cycles. Errors arriving meanwhile are not logged;
	// they are consequential unless a fault reset clears the fault flag mid-walk.
	logic shift_phase_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= ehl_pkg::ST_IDLE;
			walk_r <= '0;
			shift_busy_r <= 1'b0;
			shift_idx_r <= '0;
			shift_phase_r <= 1'b0;
			pending_r <= '0;
		end else begin
			case (state_r)
				ehl_pkg::ST_IDLE: begin
					if (wr_erase) begin
						state_r <= ehl_pkg::ST_ERASE; // R7
						walk_r <= '0;
						shift_busy_r <= 1'b0;
					end else if (shift_busy_r) begin
						shift_phase_r <= !shift_phase_r;
						if (shift_phase_r) begin
							if (is_last(shift_idx_r)) begin
								shift_busy_r <= 1'b0;
							end else begin
								shift_idx_r <= inc_ptr(shift_idx_r);
							end
						end
					end else if (new_err) begin
						pending_r.num <= err_num; // R3
						pending_r.cls <= err_class; // R16
						pending_r.tim <= clamp_time(op_seconds); // R17
						pending_r.info <= err_info; // R18
						if (full) begin
							shift_busy_r <= 1'b1; // R20
							shift_idx_r <= '0;
							shift_phase_r <= 1'b0;
						end
					end
				end
				ehl_pkg::ST_ERASE: begin
					walk_r <= inc_ptr(walk_r);
					if (is_last(walk_r)) begin
						state_r <= ehl_pkg::ST_IDLE;
					end
				end
				default: state_r <= ehl_pkg::ST_IDLE;
			endcase
		end
	end

	// The count sits beside the store and, like it, ignores the logic reset, so the history
	// is readable again after a power cycle. A store never erased starts from an unknown count.
	always_ff @(posedge clk) begin // R6
		if (erase_done) begin
			count_r <= '0; // R7
		end else if (resetn && log_start && !full) begin
			count_r <= inc_ptr(count_r); // R5
		end
	end

	// Store access: newest goes at the highest occupied slot, oldest at slot 0.
	logic log_now_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			log_now_r <= 1'b0;
		end else begin
			log_now_r <= log_start && !full;
		end
	end

	// A shift walk borrows the read port, so an entry read during a walk may see a slot
	// in motion; the master should let a logged error settle before reading the history.
	always_comb begin
		mif.we = 1'b0;
		mif.waddr = '0;
		mif.wdata = '0;
		mif.raddr = rd_ptr_r;
		if (state_r == ehl_pkg::ST_ERASE) begin
			mif.we = 1'b1;
			mif.waddr = walk_r;
		end else if (shift_busy_r) begin
			if (!shift_phase_r) begin
				mif.raddr = is_last(shift_idx_r) ? shift_idx_r : inc_ptr(shift_idx_r);
			end else begin
				mif.we = 1'b1;
				mif.waddr = shift_idx_r; // R20
				mif.wdata = is_last(shift_idx_r) ? pending_r : mif.rdata; // R13
			end
		end else if (log_now_r) begin
			mif.we = 1'b1;
			mif.waddr = count_r - 4'h1; // R13
			mif.wdata = pending_r; // R6
		end
	end

	// ----------------------------------------------------------------
	// Sequential read-out
	// ----------------------------------------------------------------
	// The pointer stops one past the last slot so further reads keep answering zero.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_ptr_r <= '0;
		end else if (wr_ptr_reset) begin
			rd_ptr_r <= '0; // R9
		end else if (rd_num && rd_ptr_r != 4'(ehl_pkg::DEPTH)) begin
			rd_ptr_r <= inc_ptr(rd_ptr_r); // R11
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			latch_pend_r <= 1'b0;
			latch_empty_r <= 1'b0;
			hold_r <= '0;
		end else begin
			// Store data is one cycle behind the address, so the latch lands a cycle later.
			latch_pend_r <= rd_num;
			latch_empty_r <= rd_ptr_r >= count_r; // R12
			if (latch_pend_r) begin
				hold_r <= latch_empty_r ? '0 : mif.rdata; // R15
			end
		end
	end

	// ----------------------------------------------------------------
	// Parameter answers
	// ----------------------------------------------------------------
	// Reads answer two cycles after the strobe. The holding store loads at that same edge, so the
	// error number is taken from the store output on its way in rather than from the old hold.
	logic rd_d_r;
	logic [15:0] rd_addr_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_d_r <= 1'b0;
			rd_addr_r <= ehl_pkg::ZERO16;
		end else begin
			rd_d_r <= par_rd;
			rd_addr_r <= par_addr;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			par_rdata <= '0;
			par_ack <= 1'b0;
		end else begin
			par_ack <= par_wr || rd_d_r;
			par_rdata <= '0;
			if (rd_d_r) begin
				case (rd_addr_r)
					ehl_pkg::ADDR_ERASE: par_rdata[15:0] <= (state_r == ehl_pkg::ST_ERASE) ? ehl_pkg::CMD_ONE : ehl_pkg::ZERO16; // R8
					ehl_pkg::ADDR_ERR_NUM: par_rdata[15:0] <= latch_empty_r ? ehl_pkg::ZERO16 : mif.rdata.num; // R12
					ehl_pkg::ADDR_CLASS: par_rdata[15:0] <= {13'h0000, hold_r.cls}; // R16
					ehl_pkg::ADDR_TIME: par_rdata <= hold_r.tim; // R17
					ehl_pkg::ADDR_EXTRA: par_rdata[15:0] <= hold_r.info; // R18
					default: par_rdata <= '0;
				endcase
			end
		end
	end
endmodule

// File: verification/ehl_chk.sv
`timescale 1ns/1ps
// Purpose: Port checks of the error history log.
// Assumes: Acks and status follow the fixed latencies of the block.
// Notes: Sees the top module's ports only.
module ehl_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Requests
	input wire logic err_evt,
	input wire logic [15:0] err_num,
	input wire logic par_rd,
	input wire logic par_wr,
	input wire logic [15:0] par_addr,
	// Answers
	input wire logic [31:0] par_rdata,
	input wire logic par_ack,
	input wire logic [15:0] drive_status_word,
	input wire logic [15:0] last_interrupt_cause
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire logic flt = drive_status_word[13];
	property p_wr_ack; par_wr |=> par_ack; endproperty
	a_wr_ack: assert property (p_wr_ack) else $error("write not acked");
	property p_rd_ack; par_rd |-> ##2 par_ack; endproperty
	a_rd_ack: assert property (p_rd_ack) else $error("read not acked");
	property p_idle; !par_ack |-> par_rdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("read data outside ack");
	property p_err_bit; err_evt && !flt |-> ##2 flt; endproperty
	a_err_bit: assert property (p_err_bit) else $error("error bit not set");
	property p_oper; flt |-> drive_status_word[3:0] == 4'h8; endproperty
	a_oper: assert property (p_oper) else $error("operating state not changed");
	property p_cause;
		err_evt && !flt && !$past(err_evt) |-> ##2 last_interrupt_cause == $past(err_num, 2);
	endproperty
	a_cause: assert property (p_cause) else $error("wrong cause");
	property p_no_cause; !flt |-> last_interrupt_cause == 16'h0000; endproperty
	a_no_cause: assert property (p_no_cause) else $error("cause without error");
	property p_hold; flt && $past(flt) |-> $stable(last_interrupt_cause); endproperty
	a_hold: assert property (p_hold) else $error("cause replaced");
	c_erase: cover property (par_wr && par_addr == ehl_pkg::ADDR_ERASE);
	c_num: cover property (par_rd && par_addr == ehl_pkg::ADDR_ERR_NUM);
	c_flt: cover property ($rose(flt));
endmodule
bind ehl_top ehl_chk ehl_chk_inst (.clk(clk), .resetn(resetn), .err_evt(err_evt), .err_num(err_num),
	.par_rd(par_rd), .par_wr(par_wr), .par_addr(par_addr), .par_rdata(par_rdata), .par_ack(par_ack),
	.drive_status_word(drive_status_word), .last_interrupt_cause(last_interrupt_cause));

// File: verification/ehl_master.sv
`timescale 1ns/1ps
// Purpose: Fieldbus master model issuing parameter reads and writes.
// Assumes: Strobes last one cycle; address and data stay until the ack.
// Notes: Idle address and data wander so stale values are never trusted.
module ehl_master (
	// Clock
	input wire logic clk,
	// Parameter bus
	output logic par_rd,
	output logic par_wr,
	output logic [15:0] par_addr,
	output logic [31:0] par_wdata,
	input wire logic par_ack
);
	int seed = 32'h0D488AFB;
	initial begin
		par_rd = 1'b0;
		par_wr = 1'b0;
		par_addr = 16'h0000;
		par_wdata = 32'h0;
	end
	function automatic int rnd();
		return $random(seed);
	endfunction
	task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(negedge clk);
		par_rd = !wr;
		par_wr = wr;
		par_addr = a;
		par_wdata = d;
		@(negedge clk);
		par_rd = 1'b0;
		par_wr = 1'b0;
		while (par_ack !== 1'b1 && n < 6) begin
			@(negedge clk);
			n++;
		end
		par_addr = 16'(rnd());
		par_wdata = rnd();
	endtask
endmodule

// File: verification/ehl_top_tb.sv
`timescale 1ns/1ps
// Purpose: Self-checking bench of the error history log.
// Assumes: Expected answers are queued by the driver and popped at each ack.
// Notes: The history model keeps the ten newest entries with clamped times.
module ehl_top_tb;
	logic clk = 1'b0;
	logic resetn, err_evt, fault_reset, par_rd, par_wr, par_ack;
	logic [15:0] err_num, err_info, par_addr, drive_status_word, last_interrupt_cause;
	logic [2:0] err_class;
	logic [3:0] oper_state;
	logic [31:0] op_seconds, par_wdata, par_rdata;
	logic [32:0] e;
	int fail_count = 0;
	int compares = 0;
	logic [32:0] q[$];
	ehl_pkg::ehl_entry_type hist[$];
	always #25 clk = ~clk;
	ehl_top ehl_top_inst (.clk(clk), .resetn(resetn), .err_evt(err_evt), .err_num(err_num),
		.err_class(err_class), .err_info(err_info), .op_seconds(op_seconds), .fault_reset(fault_reset),
		.oper_state(oper_state), .par_rd(par_rd), .par_wr(par_wr), .par_addr(par_addr),
		.par_wdata(par_wdata), .par_rdata(par_rdata), .par_ack(par_ack),
		.drive_status_word(drive_status_word), .last_interrupt_cause(last_interrupt_cause));
	ehl_master ehl_master_inst (.clk(clk), .par_rd(par_rd), .par_wr(par_wr), .par_addr(par_addr),
		.par_wdata(par_wdata), .par_ack(par_ack));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		if (q.size() != 0) begin
			fail_count++;
			$display("mismatch at %0t: %0d answers never came", $time, q.size());
		end
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] x);
		q.push_back({1'b1, x});
		ehl_master_inst.xfer(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		q.push_back(33'h0);
		ehl_master_inst.xfer(1'b1, a, d);
	endtask
	task automatic log_err(input logic [2:0] c);
		ehl_pkg::ehl_entry_type x;
		logic [31:0] s;
		x.num = 16'(ehl_master_inst.rnd()) | 16'h0001;
		x.cls = c;
		x.info = 16'(ehl_master_inst.rnd());
		s = ehl_master_inst.rnd();
		// Higher classes draw smaller times so both sides of the clamp are seen.
		s = s >> c;
		x.tim = (s > ehl_pkg::TIME_MAX) ? ehl_pkg::TIME_MAX : s;
		@(negedge clk);
		err_evt = 1'b1;
		err_num = x.num;
		err_class = c;
		err_info = x.info;
		op_seconds = s;
		oper_state = 4'(ehl_master_inst.rnd());
		@(negedge clk);
		err_evt = 1'b0;
		err_num = ~x.num;
		err_info = ~x.info;
		op_seconds = ~s;
		hist.push_back(x);
		if (hist.size() > ehl_pkg::DEPTH) void'(hist.pop_front());
		repeat (3) @(negedge clk);
		chk(drive_status_word[13], 32'h1);
		chk(last_interrupt_cause, x.num);
		// A follow-on error must neither replace the cause nor reach the history.
		err_evt = 1'b1;
		@(negedge clk);
		err_evt = 1'b0;
		repeat (25) @(negedge clk);
		chk(last_interrupt_cause, x.num);
		if (c != 3'h4) begin
			fault_reset = 1'b1;
			@(negedge clk);
			fault_reset = 1'b0;
			repeat (3) @(negedge clk);
			chk(last_interrupt_cause, 32'h0);
			chk(drive_status_word[3:0], oper_state);
		end
	endtask
	task automatic entry(input int i);
		ehl_pkg::ehl_entry_type x;
		x = (i < hist.size()) ? hist[i] : '0;
		rd(ehl_pkg::ADDR_ERR_NUM, {16'h0000, x.num});
		if (i < hist.size()) begin
			rd(ehl_pkg::ADDR_CLASS, {29'h0, x.cls});
			rd(ehl_pkg::ADDR_TIME, x.tim);
			rd(ehl_pkg::ADDR_EXTRA, {16'h0000, x.info});
		end
	endtask
	always @(negedge clk) begin
		if (par_ack === 1'b1) begin
			if (q.size() == 0) chk(32'h1, 32'h0);
			else begin
				e = q.pop_front();
				if (e[32]) chk(par_rdata, e[31:0]);
			end
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		close_out();
	end
	initial begin
		resetn = 1'b0;
		err_evt = 1'b0;
		err_num = 16'h0000;
		err_class = 3'h0;
		err_info = 16'h0000;
		op_seconds = 32'h0;
		fault_reset = 1'b0;
		oper_state = 4'h0;
		repeat (10) @(posedge clk);
		@(negedge clk);
		resetn = 1'b1;
		wr(ehl_pkg::ADDR_ERASE, 32'h1);
		rd(ehl_pkg::ADDR_ERASE, 32'h1);
		repeat (12) @(negedge clk);
		rd(ehl_pkg::ADDR_ERASE, 32'h0);
		rd(16'h3B00, 32'h0);
		for (int i = 0; i < 12; i++) log_err((i == 11) ? 3'h4 : 3'(i % 4));
		fault_reset = 1'b1;
		@(negedge clk);
		fault_reset = 1'b0;
		repeat (3) @(negedge clk);
		chk(drive_status_word[13], 32'h1);
		// A second reset stands in for a power cycle: the fault goes, the history stays.
		resetn = 1'b0;
		repeat (3) @(negedge clk);
		resetn = 1'b1;
		repeat (2) @(negedge clk);
		chk(drive_status_word[13], 32'h0);
		chk(last_interrupt_cause, 32'h0);
		chk(drive_status_word[3:0], oper_state);
		wr(ehl_pkg::ADDR_PTR_RESET, 32'h1);
		for (int i = 0; i < 11; i++) entry(i);
		repeat (2) @(negedge clk);
		close_out();
	end
endmodule
